// *** design/ufo_filter.sv ***
// upstream-only egress filter for up to sixteen isolating vlans
// assumes lookup requests and topology inputs are synchronous to CLOCK,
// and an apb master that holds each request until pready is seen
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module ufo_filter (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // port and topology state
    input wire ufo_filter_pkg::port_mask_t LINK_UP,
    input wire ufo_filter_pkg::port_mask_t PORT_BLOCKED,
    input wire ufo_filter_pkg::slot_masks_t VLAN_BLOCKED,
    input wire ufo_filter_pkg::slot_masks_t TREE_ROOT_PORT,
    input wire ufo_filter_pkg::slot_masks_t RING_MASTER_SEEN,
    input wire ufo_filter_pkg::slot_flags_t RING_PROTECTED,
    // lookup in from ingress
    input wire logic LOOKUP_VALID,
    input wire ufo_filter_pkg::lookup_s LOOKUP_IN,
    // filtered mask out to egress
    output logic FILTER_VALID,
    output ufo_filter_pkg::port_mask_t FILTER_MASK,
    // vlans left with no upstream member
    output ufo_filter_pkg::slot_flags_t NO_UPLINK
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    // two-stage release of the asynchronous reset
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // sixteen slots
    logic [ufo_filter_pkg::VID_W-1:0] vid_ff [ufo_filter_pkg::NUM_SLOTS];
    logic slot_en_ff [ufo_filter_pkg::NUM_SLOTS];
    ufo_filter_pkg::slot_masks_t member_ff;
    logic [ufo_filter_pkg::NUM_PORTS*ufo_filter_pkg::MODE_W-1:0] mode_ff
        [ufo_filter_pkg::NUM_SLOTS];

    logic apb_access;
    logic apb_commit;
    logic [1:0] area;
    logic [ufo_filter_pkg::SLOT_W-1:0] slot_sel;
    logic addr_ok;

    ufo_filter_pkg::apb_state_e apb_st_ff;

    // decode: top two bits pick the area, next four the slot
    always_comb begin
        area = PADDR[7:6];
        slot_sel = PADDR[5:2];
        addr_ok = (PADDR[1:0] == 2'h0);
        if (area == ufo_filter_pkg::AREA_STAT) begin
            addr_ok = (PADDR == ufo_filter_pkg::NO_UPLINK_ADDR);
        end
        apb_access = PSEL && PENABLE && (apb_st_ff == ufo_filter_pkg::APB_IDLE);
        // the edge at which the master sees pready high
        apb_commit = PSEL && PENABLE && (apb_st_ff == ufo_filter_pkg::APB_DONE);
    end

    // software writes land only at the edge that completes the transfer
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            for (int s = 0; s < ufo_filter_pkg::NUM_SLOTS; s++) begin
                vid_ff[s] <= ufo_filter_pkg::VID_RESET;
                slot_en_ff[s] <= 1'b0;
                member_ff[s] <= ufo_filter_pkg::MEMBER_RESET;
                mode_ff[s] <= '0;
            end
        end else if (apb_commit && PWRITE && addr_ok) begin
            if (area == ufo_filter_pkg::AREA_CFG) begin
                vid_ff[slot_sel] <=
                    PWDATA[ufo_filter_pkg::CFG_VID_LSB +: ufo_filter_pkg::VID_W];
                slot_en_ff[slot_sel] <= PWDATA[ufo_filter_pkg::CFG_EN_BIT];
                member_ff[slot_sel] <=
                    PWDATA[ufo_filter_pkg::CFG_MEM_LSB +: ufo_filter_pkg::NUM_PORTS];
            end else if (area == ufo_filter_pkg::AREA_MODE) begin
                mode_ff[slot_sel] <=
                    PWDATA[ufo_filter_pkg::NUM_PORTS*ufo_filter_pkg::MODE_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // role computation per slot and port
    // ----------------------------------------------------------------
    ufo_filter_pkg::slot_masks_t nxt_up;
    ufo_filter_pkg::slot_flags_t nxt_no_uplink;
    ufo_filter_pkg::slot_masks_t up_ff;
    ufo_filter_pkg::slot_flags_t no_uplink_ff;

    always_comb begin
        ufo_filter_pkg::port_mask_t avail;
        ufo_filter_pkg::port_mask_t prim;
        ufo_filter_pkg::port_mask_t sec;
        ufo_filter_pkg::port_mask_t stat;
        ufo_filter_pkg::port_mask_t tree;
        ufo_filter_pkg::port_mask_t ring;
        logic prim_alive;
        logic [ufo_filter_pkg::MODE_W-1:0] m;
        avail = '0;
        prim = '0;
        sec = '0;
        stat = '0;
        tree = '0;
        ring = '0;
        prim_alive = 1'b0;
        m = ufo_filter_pkg::MODE_DOWN;
        nxt_up = '0;
        nxt_no_uplink = '0;
        for (int s = 0; s < ufo_filter_pkg::NUM_SLOTS; s++) begin
            avail = LINK_UP & ~PORT_BLOCKED & ~VLAN_BLOCKED[s];
            for (int p = 0; p < ufo_filter_pkg::NUM_PORTS; p++) begin
                m = mode_ff[s][p*ufo_filter_pkg::MODE_W +: ufo_filter_pkg::MODE_W];
                stat[p] = (m == ufo_filter_pkg::MODE_STATIC);
                prim[p] = (m == ufo_filter_pkg::MODE_PRIMARY);
                sec[p] = (m == ufo_filter_pkg::MODE_SECONDARY);
                tree[p] = (m == ufo_filter_pkg::MODE_TREE);
                ring[p] = (m == ufo_filter_pkg::MODE_RING);
            end
            prim_alive = |(prim & avail & member_ff[s]);
            // default downstream, many may be upstream
            nxt_up[s] = member_ff[s] & (
                stat |
                (prim & {ufo_filter_pkg::NUM_PORTS{prim_alive}}) |
                (sec & {ufo_filter_pkg::NUM_PORTS{!prim_alive}}) |
                (tree & TREE_ROOT_PORT[s]) |
                (ring & RING_MASTER_SEEN[s] &
                    {ufo_filter_pkg::NUM_PORTS{RING_PROTECTED[s]}}));
            nxt_no_uplink[s] = slot_en_ff[s] && (member_ff[s] != '0) &&
                (nxt_up[s] == '0);
        end
    end

    // role state per slot, refreshed every cycle
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            up_ff <= '0;
            no_uplink_ff <= '0;
        end else begin
            up_ff <= nxt_up;
            no_uplink_ff <= nxt_no_uplink;
        end
    end

    assign NO_UPLINK = no_uplink_ff;

    // ----------------------------------------------------------------
    // egress filter
    // ----------------------------------------------------------------
    ufo_filter_pkg::port_mask_t nxt_mask;
    ufo_filter_pkg::port_mask_t mask_ff;
    logic valid_ff;

    always_comb begin
        logic hit;
        logic src_up;
        ufo_filter_pkg::port_mask_t allow;
        hit = 1'b0;
        src_up = 1'b0;
        allow = '1;
        for (int s = 0; s < ufo_filter_pkg::NUM_SLOTS; s++) begin
            if (!hit && slot_en_ff[s] && (vid_ff[s] == LOOKUP_IN.vid)) begin
                hit = 1'b1;
                src_up = up_ff[s][LOOKUP_IN.src_port];
                // downstream source keeps upstream members and all non-member ports
                allow = up_ff[s] | ~member_ff[s];
            end
        end
        if (src_up) begin
            allow = '1;
        end
        // unmatched vlans keep the full mask
        if (!hit) begin
            allow = '1;
        end
        nxt_mask = LOOKUP_IN.egress & allow;
    end

    // registered filter answer, one cycle after the request
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            valid_ff <= 1'b0;
            mask_ff <= '0;
        end else begin
            valid_ff <= LOOKUP_VALID;
            mask_ff <= LOOKUP_VALID ? nxt_mask : '0;
        end
    end

    assign FILTER_VALID = valid_ff;
    assign FILTER_MASK = mask_ff;

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;
    logic ready_ff;
    logic err_ff;

    // read mux over all areas
    always_comb begin
        nxt_rdata = ufo_filter_pkg::ZERO_WORD;
        case (area)
            ufo_filter_pkg::AREA_CFG: begin
                nxt_rdata[ufo_filter_pkg::CFG_VID_LSB +: ufo_filter_pkg::VID_W] =
                    vid_ff[slot_sel];
                nxt_rdata[ufo_filter_pkg::CFG_EN_BIT] = slot_en_ff[slot_sel];
                nxt_rdata[ufo_filter_pkg::CFG_MEM_LSB +: ufo_filter_pkg::NUM_PORTS] =
                    member_ff[slot_sel];
            end
            ufo_filter_pkg::AREA_MODE: begin
                nxt_rdata[ufo_filter_pkg::NUM_PORTS*ufo_filter_pkg::MODE_W-1:0] =
                    mode_ff[slot_sel];
            end
            ufo_filter_pkg::AREA_STAT: begin
                nxt_rdata[ufo_filter_pkg::NUM_SLOTS-1:0] = no_uplink_ff;
            end
            default: begin
                nxt_rdata[ufo_filter_pkg::NUM_PORTS-1:0] = up_ff[slot_sel];
            end
        endcase
        if (!addr_ok) begin
            nxt_rdata = ufo_filter_pkg::ZERO_WORD;
        end
    end

    // one wait state: pready rises the cycle after the access phase opens
    always_ff @(posedge CLOCK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            apb_st_ff <= ufo_filter_pkg::APB_IDLE;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= ufo_filter_pkg::ZERO_WORD;
        end else begin
            case (apb_st_ff)
                ufo_filter_pkg::APB_IDLE: begin
                    ready_ff <= apb_access;
                    err_ff <= apb_access && !addr_ok;
                    rdata_ff <= (apb_access && !PWRITE) ? nxt_rdata
                                                        : ufo_filter_pkg::ZERO_WORD;
                    if (apb_access) begin
                        apb_st_ff <= ufo_filter_pkg::APB_DONE;
                    end
                end
                ufo_filter_pkg::APB_DONE: begin
                    ready_ff <= 1'b0;
                    err_ff <= 1'b0;
                    rdata_ff <= ufo_filter_pkg::ZERO_WORD;
                    apb_st_ff <= ufo_filter_pkg::APB_IDLE;
                end
                default: begin
                    apb_st_ff <= ufo_filter_pkg::APB_IDLE;
                end
            endcase
        end
    end

    assign PREADY = ready_ff;
    assign PSLVERR = err_ff;
    assign PRDATA = rdata_ff;

endmodule

// *** design/ufo_filter_pkg.sv ***
// package for the per-vlan upstream/downstream egress filter
// assumes one switch core clock and an apb master with 32-bit data
package ufo_filter_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_PORTS = 8;
    localparam int NUM_SLOTS = 16;
    localparam int PORT_W = 3;
    localparam int SLOT_W = 4;
    localparam int VID_W = 12;
    localparam int MODE_W = 3;

    typedef logic [NUM_PORTS-1:0] port_mask_t;
    typedef port_mask_t [NUM_SLOTS-1:0] slot_masks_t;
    typedef logic [NUM_SLOTS-1:0] slot_flags_t;

    // ----------------------------------------------------------------
    // register map (byte addresses, one word per register)
    // ----------------------------------------------------------------
    localparam logic [7:0] SLOT_CFG_BASE = 8'h00;   // 16 words: vid, enable, members
    localparam logic [7:0] PORT_MODE_BASE = 8'h40;  // 16 words: mode per port
    localparam logic [7:0] NO_UPLINK_ADDR = 8'h80;  // enabled slots with members, every member downstream
    localparam logic [7:0] UP_MASK_BASE = 8'hc0;    // 16 words: computed upstream mask
    localparam logic [1:0] AREA_CFG = 2'h0;
    localparam logic [1:0] AREA_MODE = 2'h1;
    localparam logic [1:0] AREA_STAT = 2'h2;
    localparam logic [1:0] AREA_UP = 2'h3;

    // slot config field layout
    localparam int CFG_VID_LSB = 0;
    localparam int CFG_EN_BIT = 15;
    localparam int CFG_MEM_LSB = 16;

    localparam logic [VID_W-1:0] VID_RESET = 12'h000;
    localparam port_mask_t MEMBER_RESET = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ----------------------------------------------------------------
    // member port role sources (3 bits per port in the mode word)
    // ----------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_DOWN = 3'h0;
    localparam logic [MODE_W-1:0] MODE_STATIC = 3'h1;
    localparam logic [MODE_W-1:0] MODE_PRIMARY = 3'h2;
    localparam logic [MODE_W-1:0] MODE_SECONDARY = 3'h3;
    localparam logic [MODE_W-1:0] MODE_TREE = 3'h4;
    localparam logic [MODE_W-1:0] MODE_RING = 3'h5;

    // ----------------------------------------------------------------
    // lookup carrier between ingress lookup and egress mask
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [VID_W-1:0] vid;
        logic [PORT_W-1:0] src_port;
        port_mask_t egress;
    } lookup_s;

    typedef enum logic [1:0] {
        APB_IDLE,
        APB_DONE
    } apb_state_e;

endpackage

// *** sim/ufo_filter_props.sv ***
// checker for the upstream-only egress filter, top ports only
// assumes CLOCK rising edge and the raw active-low NRST
`timescale 1ns/1ps

module ufo_filter_props (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // lookup and result
    input wire logic LOOKUP_VALID,
    input wire ufo_filter_pkg::lookup_s LOOKUP_IN,
    input wire logic FILTER_VALID,
    input wire ufo_filter_pkg::port_mask_t FILTER_MASK,
    input wire ufo_filter_pkg::slot_flags_t NO_UPLINK
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_quiet;
        !FILTER_VALID && !PREADY && NO_UPLINK == 16'h0000;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_apb_answer;
        s_access |=> PREADY ##1 !PREADY;
    endproperty
    property p_err_unmapped;
        s_access and (PADDR >= 8'h84 && PADDR <= 8'hbc) |=> PSLVERR;
    endproperty
    property p_slot_ok;
        s_access and (PADDR < 8'h80 && PADDR[1:0] == 2'h0) |=> !PSLVERR;
    endproperty
    property p_err_ready;
        PSLVERR |-> PREADY && PRDATA == 32'h0000_0000;
    endproperty
    property p_rdata_idle;
        !PREADY |-> PRDATA == 32'h0000_0000;
    endproperty
    property p_lookup_answer;
        LOOKUP_VALID |=> FILTER_VALID;
    endproperty
    property p_filter_idle;
        !LOOKUP_VALID |=> !FILTER_VALID && FILTER_MASK == 8'h00;
    endproperty
    property p_filter_subset;
        LOOKUP_VALID |=> (FILTER_MASK & ~$past(LOOKUP_IN.egress)) == 8'h00;
    endproperty
    property p_status_read;
        s_access and (!PWRITE && PADDR == 8'h80 && $stable(NO_UPLINK))
            |=> PRDATA[15:0] == $past(NO_UPLINK);
    endproperty
    property p_after_reset;
        $rose(NRST) |-> s_quiet ##1 s_quiet;
    endproperty

    a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one pulse");
    a_err_unmapped: assert property (p_err_unmapped) else $error("hole not refused");
    a_slot_ok: assert property (p_slot_ok) else $error("slot area refused");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ready");
    a_lookup_answer: assert property (p_lookup_answer) else $error("lookup unanswered");
    a_filter_idle: assert property (p_filter_idle) else $error("result without lookup");
    a_filter_subset: assert property (p_filter_subset) else $error("mask widened");
    a_status_read: assert property (p_status_read) else $error("status read wrong");
    a_after_reset: assert property (p_after_reset) else $error("outputs busy after reset");
endmodule

bind ufo_filter ufo_filter_props ufo_filter_props_i (.CLOCK(CLOCK), .NRST(NRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LOOKUP_VALID(LOOKUP_VALID),
    .LOOKUP_IN(LOOKUP_IN), .FILTER_VALID(FILTER_VALID), .FILTER_MASK(FILTER_MASK),
    .NO_UPLINK(NO_UPLINK));

// *** sim/fwd_engine_model.sv ***
// ingress lookup engine model feeding the filter
// assumes requests from the bench one cycle ahead, same clock
`timescale 1ns/1ps

module fwd_engine_model (
    // clock
    input wire logic clock,
    // request from bench
    input wire logic go,
    input wire ufo_filter_pkg::lookup_s req,
    // filter lookup side
    output ufo_filter_pkg::lookup_s lookup_in,
    output logic lookup_valid,
    input wire logic filter_valid,
    input wire ufo_filter_pkg::port_mask_t filter_mask,
    // captured answer
    output ufo_filter_pkg::port_mask_t result,
    output logic result_v
);
    // one lookup per go cycle; idle carrier shows the inverse of the request
    always_ff @(posedge clock) begin
        lookup_valid <= go;
        lookup_in <= go ? req : ~req;
    end
    // take the filtered mask in the one cycle it stands
    always_ff @(posedge clock) begin
        result_v <= filter_valid;
        if (filter_valid) begin
            result <= filter_mask;
        end
    end
endmodule

// *** sim/upstream_only_port_filter_test.sv ***
// self-checking bench for the upstream-only egress filter
// assumes the filter package and a 100 MHz core clock
`timescale 1ns/1ps

module upstream_only_port_filter_test;
    typedef struct {
        logic [11:0] vid;
        logic [2:0] src;
        logic [7:0] egr;
        logic [7:0] exp;
    } row_s;
    logic clock, nrst, psel, penable, pwrite, pready, pslverr, er, go, result_v;
    logic lookup_valid, filter_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    ufo_filter_pkg::port_mask_t link_up, port_blocked, filter_mask, result;
    ufo_filter_pkg::slot_masks_t vlan_blocked, tree_root, ring_seen;
    ufo_filter_pkg::slot_flags_t ring_prot, no_uplink;
    ufo_filter_pkg::lookup_s lookup_in, req;
    int errors, checks_done, cycles;
    // slot0 up 01, slot1 up 0c, slot2 up b0
    row_s rows [8] = '{'{12'h00a, 3'h1, 8'hff, 8'hf1}, '{12'h00a, 3'h0, 8'hfe, 8'hfe},
        '{12'h014, 3'h5, 8'hff, 8'hcf}, '{12'h014, 3'h2, 8'h3c, 8'h3c},
        '{12'h01e, 3'h6, 8'hff, 8'hbf}, '{12'h01e, 3'h4, 8'hff, 8'hff},
        '{12'h028, 3'h1, 8'hff, 8'hff}, '{12'h00a, 3'h5, 8'h0e, 8'h00}};

    ufo_filter ufo_filter_i (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK_UP(link_up), .PORT_BLOCKED(port_blocked),
        .VLAN_BLOCKED(vlan_blocked), .TREE_ROOT_PORT(tree_root),
        .RING_MASTER_SEEN(ring_seen), .RING_PROTECTED(ring_prot),
        .LOOKUP_VALID(lookup_valid), .LOOKUP_IN(lookup_in), .FILTER_VALID(filter_valid),
        .FILTER_MASK(filter_mask), .NO_UPLINK(no_uplink));
    fwd_engine_model fwd_engine_model_i (.clock(clock), .go(go), .req(req),
        .lookup_in(lookup_in), .lookup_valid(lookup_valid), .filter_valid(filter_valid),
        .filter_mask(filter_mask), .result(result), .result_v(result_v));

    // ----------------------------------------------------------------
    // clock, timeout and verdict
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("ERROR at %0t: timeout", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // compare, apb and lookup tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check({31'h0, pready}, 32'h1);
    endtask
    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
        check({31'h0, er}, 32'h0);
    endtask
    task automatic look(input logic [11:0] vid, input logic [2:0] src,
        input logic [7:0] egr, input logic [7:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        go <= 1'b1;
        req <= {vid, src, egr};
        @(posedge clock);
        go <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (result_v !== 1'b1 && n < 10);
        check({23'h0, result_v, result}, {23'h0, 1'b1, exp});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        errors = 0;
        checks_done = 0;
        cycles = 0;
        nrst = 1'b0;
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req = '0;
        link_up = 8'hff;
        port_blocked = 8'h00;
        vlan_blocked = '0;
        tree_root = '0;
        ring_seen = '0;
        ring_prot = 16'h0004;
        tree_root[2] = 8'h10;
        ring_seen[2] = 8'h20;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        check({16'h0, no_uplink}, 32'h0);
        rdchk(ufo_filter_pkg::PORT_MODE_BASE, 32'h0);
        apb(1'b1, 8'h00, 32'h000f_800a);
        apb(1'b1, 8'h40, 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h003c_8014);
        apb(1'b1, 8'h44, 32'h0000_3480);
        apb(1'b1, 8'h08, 32'h00f0_801e);
        apb(1'b1, 8'h48, 32'h0022_c000);
        rdchk(8'hc0, 32'h01);
        rdchk(8'hc4, 32'h0c);
        rdchk(8'hc8, 32'hb0);
        foreach (rows[i]) begin
            look(rows[i].vid, rows[i].src, rows[i].egr, rows[i].exp);
        end
        // primary failover and return
        link_up <= 8'hf3;
        rdchk(8'hc4, 32'h10);
        look(12'h014, 3'h5, 8'hff, 8'hd3);
        link_up <= 8'hfb;
        vlan_blocked[1] <= 8'h08;
        rdchk(8'hc4, 32'h10);
        vlan_blocked[1] <= 8'h00;
        port_blocked <= 8'h08;
        rdchk(8'hc4, 32'h10);
        port_blocked <= 8'h00;
        rdchk(8'hc4, 32'h0c);
        link_up <= 8'hff;
        tree_root[2] <= 8'h00;
        rdchk(8'hc8, 32'ha0);
        ring_prot <= 16'h0000;
        rdchk(8'hc8, 32'h80);
        // slot with no upstream member, then one made static
        apb(1'b1, 8'h0c, 32'h0003_8032);
        rdchk(ufo_filter_pkg::NO_UPLINK_ADDR, 32'h0008);
        check({16'h0, no_uplink}, 32'h0008);
        apb(1'b1, ufo_filter_pkg::NO_UPLINK_ADDR, 32'hffff);
        rdchk(ufo_filter_pkg::NO_UPLINK_ADDR, 32'h0008);
        apb(1'b0, 8'h84, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 8'h4c, 32'h0000_0001);
        rdchk(ufo_filter_pkg::NO_UPLINK_ADDR, 32'h0000);
        rdchk(8'h00, 32'h000f_800a);
        // mid-run reset clears configuration and roles
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rdchk(8'h00, 32'h0);
        rdchk(8'hcc, 32'h0);
        check({16'h0, no_uplink}, 32'h0);
        end_of_test();
    end
endmodule
